// ===== debug_defines.svh
`ifndef DEBUG_DEFINES_SVH
`define DEBUG_DEFINES_SVH
`define CTL_RESET 8'h00
`define CTL_HALT_BIT 7
`define CTL_BREAK_EN_BIT 6
`define CTL_ACK_BIT 5
`define CTL_RST_BIT 0
`define CTL_WRITE_MASK 8'hE1
`define BREAK_OPCODE 8'h00
`define ACK_CHAR 8'hFF
`define UNLOCK_K0 8'h80
`define UNLOCK_K1 8'hEB
`define UNLOCK_K2 8'h5A
`define UNLOCK_K3 8'h70
`define UNLOCK_K4 8'hCD
`define RUNTIME_MAX 16'hFFFF
`endif

// ===== debug_pkg.sv
package debug_pkg;
    // Unlock byte tracking
    typedef enum logic [2:0] {UL_K0, UL_K1, UL_K2, UL_K3, UL_K4, UL_DONE} unlock_state_t;
    // Register write from the serial command decoder
    typedef struct packed {
        logic       wr;
        logic [7:0] data;
    } ctl_write_t;
endpackage

// ===== on_chip_debug_unit.sv
`timescale 1ns/100ps
`include "debug_defines.svh"
module on_chip_debug_unit
    import debug_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic sys_reset_active,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire ctl_write_t ctl_write,
    input wire logic opcode_decode,
    input wire logic [7:0] opcode,
    input wire logic read_protect,
    input wire logic reset_seq_done,
    input wire logic ack_tx_ready,
    output logic debug_pin_enabled,
    output logic [7:0] debug_control,
    output logic cpu_fetch_stall,
    output logic break_as_nop,
    output logic device_reset_req,
    output logic ack_tx_valid,
    output logic [7:0] ack_tx_data,
    output logic [15:0] runtime_count
);
    unlock_state_t ul_reg, ul_next;
    logic pin_en_reg;
    logic [7:0] ctl_reg, ctl_next;
    logic nop_reg, ack_reg;
    logic [7:0] ack_data_reg;
    logic [15:0] cnt_reg;

    // Unlock key step match, only while system reset holds
    wire logic [7:0] key_exp = (ul_reg == UL_K0) ? `UNLOCK_K0 :
                               (ul_reg == UL_K1) ? `UNLOCK_K1 :
                               (ul_reg == UL_K2) ? `UNLOCK_K2 :
                               (ul_reg == UL_K3) ? `UNLOCK_K3 : `UNLOCK_K4;
    wire logic key_hit = sys_reset_active && rx_byte_valid && rx_byte == key_exp;

    always_comb begin
        ul_next = ul_reg;
        if (!sys_reset_active) begin
            ul_next = UL_K0; // A partial key is dropped once reset is released
        end else if (rx_byte_valid && ul_reg != UL_DONE) begin
            case (ul_reg)
                UL_K0: ul_next = key_hit ? UL_K1 : UL_K0;
                UL_K1: ul_next = key_hit ? UL_K2 : UL_K0;
                UL_K2: ul_next = key_hit ? UL_K3 : UL_K0;
                UL_K3: ul_next = key_hit ? UL_K4 : UL_K0;
                UL_K4: ul_next = key_hit ? UL_DONE : UL_K0;
                default: ul_next = UL_K0;
            endcase
        end
    end

    // Pin ownership claimed during a system reset; survives the reset itself and only reset_n returns it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ul_reg <= UL_K0;
            pin_en_reg <= 1'b0;
        end else if (clk_en) begin
            ul_reg <= ul_next;
            if (sys_reset_active && ul_next == UL_DONE) begin
                pin_en_reg <= 1'b1;
            end else if (sys_reset_active && ul_reg == UL_K0 && !rx_byte_valid && !pin_en_reg) begin
                pin_en_reg <= 1'b0;
            end
        end
    end

    // Break decode and write handling
    wire logic break_seen = opcode_decode && opcode == `BREAK_OPCODE;
    wire logic break_hit = break_seen && ctl_reg[`CTL_BREAK_EN_BIT];
    wire logic [7:0] wr_val = ctl_write.data & `CTL_WRITE_MASK;
    // Read protection pins the halt bit high once set
    wire logic halt_wr = (read_protect && ctl_reg[`CTL_HALT_BIT]) ? 1'b1 : wr_val[`CTL_HALT_BIT];

    always_comb begin
        ctl_next = ctl_reg;
        if (ctl_write.wr) begin
            ctl_next = wr_val;
            ctl_next[`CTL_HALT_BIT] = halt_wr;
            ctl_next[`CTL_RST_BIT] = wr_val[`CTL_RST_BIT] | ctl_reg[`CTL_RST_BIT];
        end
        if (reset_seq_done && ctl_reg[`CTL_RST_BIT]) begin
            ctl_next[`CTL_RST_BIT] = 1'b0;
        end
        if (break_hit) begin
            ctl_next[`CTL_HALT_BIT] = 1'b1;
        end
    end

    // Control register; reset bit request reaches the device reset logic
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctl_reg <= `CTL_RESET;
            nop_reg <= 1'b0;
        end else if (clk_en) begin
            ctl_reg <= ctl_next;
            nop_reg <= break_seen && !ctl_reg[`CTL_BREAK_EN_BIT];
        end
    end

    // Acknowledge character held until the transmitter takes it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_reg <= 1'b0;
            ack_data_reg <= `ACK_CHAR;
        end else if (clk_en) begin
            if (break_hit && ctl_reg[`CTL_ACK_BIT]) begin
                ack_reg <= 1'b1;
                ack_data_reg <= `ACK_CHAR;
            end else if (ack_tx_ready) begin
                ack_reg <= 1'b0;
            end
        end
    end

    // Runtime counter: runs outside debug mode, saturates rather than wraps
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_reg <= 16'h0000;
        end else if (clk_en) begin
            if (ctl_reg[`CTL_HALT_BIT]) begin
                cnt_reg <= cnt_reg;
            end else if (cnt_reg != `RUNTIME_MAX) begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end

    // Outputs from flops
    assign debug_pin_enabled = pin_en_reg;
    assign debug_control = ctl_reg;
    assign cpu_fetch_stall = ctl_reg[`CTL_HALT_BIT];
    assign break_as_nop = nop_reg;
    assign device_reset_req = ctl_reg[`CTL_RST_BIT];
    assign ack_tx_valid = ack_reg;
    assign ack_tx_data = ack_data_reg;
    assign runtime_count = cnt_reg;

    // Break handling: halt when enabled, a one-cycle no-operation mark otherwise
    chk_break_halts: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && break_hit |=> cpu_fetch_stall) else $error("break did not halt");
    chk_break_nop: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && break_seen && !ctl_reg[`CTL_BREAK_EN_BIT] && !ctl_write.wr && !cpu_fetch_stall
        |=> !cpu_fetch_stall && break_as_nop) else $error("disabled break not nop");
    chk_count_runs: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && !cpu_fetch_stall && cnt_reg != 16'hFFFF |=> cnt_reg == $past(cnt_reg) + 16'h0001)
        else $error("counter did not advance");
    chk_count_holds: assert property (@(posedge clk) disable iff (!reset_n)
        cpu_fetch_stall || cnt_reg == 16'hFFFF |=> $stable(cnt_reg)) else $error("counter moved");
    chk_write_81: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ctl_write.wr && ctl_write.data == 8'h81 && !break_hit |=> debug_control[7]
        && device_reset_req) else $error("81H write wrong");
    chk_protect_halt: assert property (@(posedge clk) disable iff (!reset_n)
        read_protect && cpu_fetch_stall ##1 read_protect |-> cpu_fetch_stall)
        else $error("halt cleared under protection");
    chk_ack_send: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && break_hit && ctl_reg[`CTL_ACK_BIT] |=> ack_tx_valid && ack_tx_data == 8'hFF)
        else $error("ack not sent");
    chk_rst_clear: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && reset_seq_done && device_reset_req && !ctl_write.wr |=> !device_reset_req)
        else $error("reset bit stuck");
    chk_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
        debug_control[4:1] == 4'h0) else $error("reserved bits set");
    chk_gpio_only: assert property (@(posedge clk) disable iff (!reset_n)
        !sys_reset_active && !debug_pin_enabled |=> !debug_pin_enabled)
        else $error("pin unlocked outside reset");
    chk_breakpoint_enable_bit_reset: assert property (@(posedge clk)
        !reset_n |=> !debug_control[6]) else $error("breakpoint enable not cleared");

    // Further break checks: the mark is a pulse, never a level
    chk_nop_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && !break_seen |=> !break_as_nop) else $error("nop mark stuck");
    chk_stall_mirror: assert property (@(posedge clk) disable iff (!reset_n)
        cpu_fetch_stall == debug_control[7]) else $error("stall differs from halt");

    // Acknowledge character must wait for a slow transmitter, then drop
    chk_ack_holds: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ack_tx_valid && !ack_tx_ready |=> ack_tx_valid)
        else $error("ack dropped early");
    chk_ack_clear: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ack_tx_valid && ack_tx_ready && !(break_hit && debug_control[5])
        |=> !ack_tx_valid) else $error("ack not released");
    chk_ack_const: assert property (@(posedge clk) disable iff (!reset_n)
        ack_tx_data == 8'hFF) else $error("ack char wrong");

    // Register writes: fields land, halt clears only when unprotected
    chk_halt_clear: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ctl_write.wr && !ctl_write.data[7] && !read_protect && !break_hit
        |=> !cpu_fetch_stall) else $error("halt not cleared");
    chk_breakpoint_enable_bit_write: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ctl_write.wr |=> debug_control[6] == $past(ctl_write.data[6]))
        else $error("break enable not written");
    chk_rst_set: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ctl_write.wr && ctl_write.data[0] && !(reset_seq_done && device_reset_req)
        |=> device_reset_req) else $error("reset bit not set");

    // Pin ownership: key completion claims the pin, nothing but reset_n returns it
    chk_unlock_done: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && sys_reset_active && rx_byte_valid && ul_reg == UL_K4 && rx_byte == 8'hCD
        |=> debug_pin_enabled) else $error("full key did not unlock");
    chk_ul_drop: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && !sys_reset_active |=> ul_reg == UL_K0) else $error("partial key kept");
    chk_pin_sticky: assert property (@(posedge clk) disable iff (!reset_n)
        debug_pin_enabled |=> debug_pin_enabled) else $error("pin ownership lost");

    // Clock enable low must freeze the control register, the runtime counter and the acknowledge valid
    chk_freeze_state: assert property (@(posedge clk) disable iff (!reset_n)
        !clk_en |=> $stable(debug_control) && $stable(runtime_count) && $stable(ack_tx_valid))
        else $error("state moved while frozen");

    // Covers for the main scenarios
    cov_unlock: cover property (@(posedge clk) disable iff (!reset_n) $rose(debug_pin_enabled));
    cov_break: cover property (@(posedge clk) disable iff (!reset_n) clk_en && break_hit);
    cov_nop: cover property (@(posedge clk) disable iff (!reset_n) break_as_nop);
    cov_saturate: cover property (@(posedge clk) disable iff (!reset_n) cnt_reg == 16'hFFFF);
    cov_resume: cover property (@(posedge clk) disable iff (!reset_n) $fell(cpu_fetch_stall));
endmodule // on_chip_debug_unit

// ===== debug_host_model.sv
`timescale 1ns/100ps
`include "debug_defines.svh"
module debug_host_model
    import debug_pkg::*;
#(parameter int ACK_WAIT = 3)
(
    input wire logic clk,
    input wire logic ack_tx_valid,
    input wire logic [7:0] ack_tx_data,
    output logic rx_byte_valid,
    output logic [7:0] rx_byte,
    output ctl_write_t ctl_write,
    output logic ack_tx_ready,
    output logic [7:0] last_ack
);
    initial begin
        rx_byte_valid = 1'b0;
        rx_byte = 8'h00;
        ctl_write = '0;
        ack_tx_ready = 1'b0;
        last_ack = 8'h00;
    end
    // Slow host: the acknowledge waits a few cycles before it is taken
    always @(posedge clk) begin
        if (ack_tx_valid && !ack_tx_ready) begin
            repeat (ACK_WAIT) @(posedge clk);
            ack_tx_ready <= 1'b1;
            last_ack <= ack_tx_data;
            @(posedge clk);
            ack_tx_ready <= 1'b0;
        end
    end
    // A released line shows the inverse, so no stale byte looks valid
    task automatic send_byte(input logic [7:0] b);
        @(posedge clk);
        rx_byte_valid <= 1'b1;
        rx_byte <= b;
        @(posedge clk);
        rx_byte_valid <= 1'b0;
        rx_byte <= ~b;
    endtask
    task automatic write_ctl(input logic [7:0] d);
        @(posedge clk);
        ctl_write <= '{wr: 1'b1, data: d};
        @(posedge clk);
        ctl_write <= '{wr: 1'b0, data: ~d};
    endtask
    // Autobaud byte first, then the key in order
    task automatic unlock_seq();
        send_byte(`UNLOCK_K0);
        send_byte(`UNLOCK_K1);
        send_byte(`UNLOCK_K2);
        send_byte(`UNLOCK_K3);
        send_byte(`UNLOCK_K4);
    endtask
endmodule // debug_host_model

// ===== on_chip_debug_unit_tb.sv
`timescale 1ns/100ps
`include "debug_defines.svh"
module on_chip_debug_unit_tb
    import debug_pkg::*;
;
    // Settle wait shortened from 5 ms to keep the run short
    localparam int RESET_SETTLE = 20;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic sys_reset_active = 1'b0;
    logic opcode_decode = 1'b0;
    logic [7:0] opcode = 8'hA5;
    logic read_protect = 1'b0;
    logic reset_seq_done = 1'b0;
    logic clk_en = 1'b1;
    logic rx_byte_valid, pin_en, stall, nop, rst_req, ack_v, ack_rdy;
    logic [7:0] rx_byte, ctl, ack_d, last_ack;
    logic [15:0] count, c;
    ctl_write_t ctl_write;
    int failures = 0;
    int cmp_count = 0;
    always #25 clk = ~clk;
    on_chip_debug_unit u_on_chip_debug_unit (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .sys_reset_active(sys_reset_active), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
        .ctl_write(ctl_write), .opcode_decode(opcode_decode), .opcode(opcode),
        .read_protect(read_protect), .reset_seq_done(reset_seq_done), .ack_tx_ready(ack_rdy),
        .debug_pin_enabled(pin_en), .debug_control(ctl), .cpu_fetch_stall(stall),
        .break_as_nop(nop), .device_reset_req(rst_req), .ack_tx_valid(ack_v),
        .ack_tx_data(ack_d), .runtime_count(count));
    debug_host_model u_debug_host_model (.clk(clk), .ack_tx_valid(ack_v), .ack_tx_data(ack_d),
        .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .ctl_write(ctl_write),
        .ack_tx_ready(ack_rdy), .last_ack(last_ack));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] d);
        u_debug_host_model.write_ctl(d);
        #1;
    endtask
    task automatic break_op();
        @(posedge clk);
        opcode_decode <= 1'b1;
        opcode <= `BREAK_OPCODE;
        @(posedge clk);
        opcode_decode <= 1'b0;
        opcode <= 8'hA5;
        #1;
    endtask
    task automatic t_unlock();
        u_debug_host_model.unlock_seq();
        check(16'(pin_en), 16'h0000);
        @(posedge clk);
        sys_reset_active <= 1'b1;
        cyc(RESET_SETTLE);
        u_debug_host_model.send_byte(`UNLOCK_K0);
        u_debug_host_model.send_byte(`UNLOCK_K2);
        cyc(2);
        check(16'(pin_en), 16'h0000);
        u_debug_host_model.unlock_seq();
        @(posedge clk);
        sys_reset_active <= 1'b0;
        cyc(2);
        check(16'(pin_en), 16'h0001);
        wr(8'h80);
        check(16'(stall), 16'h0001);
        wr(8'h00);
    endtask
    task automatic t_ctl();
        break_op();
        check({14'h0, nop, stall}, 16'h0002);
        wr(8'hFF);
        check({ctl, 7'h0, rst_req}, 16'hE101);
        c = count;
        cyc(5);
        check(count, c);
        @(posedge clk);
        reset_seq_done <= 1'b1;
        @(posedge clk);
        reset_seq_done <= 1'b0;
        cyc(1);
        check({ctl, 7'h0, rst_req}, 16'hE000);
        wr(8'h40);
        check({ctl, 7'h0, stall}, 16'h4000);
        c = count;
        cyc(10);
        check(count, c + 16'h000A);
        // Clock enable low freezes the running counter
        @(posedge clk);
        clk_en <= 1'b0;
        cyc(1);
        c = count;
        cyc(4);
        check(count, c);
        @(posedge clk);
        clk_en <= 1'b1;
        #1;
    endtask
    task automatic t_break_on();
        wr(8'h60);
        break_op();
        check({ctl, 6'h0, stall, ack_v}, 16'hE003);
        cyc(6);
        check({last_ack, 7'h0, ack_v}, 16'hFF00);
        @(posedge clk);
        read_protect <= 1'b1;
        wr(8'h00);
        check({ctl, 7'h0, stall}, 16'h8001);
        wr(8'h81);
        check({ctl, 7'h0, rst_req}, 16'h8101);
        @(posedge clk);
        read_protect <= 1'b0;
        wr(8'h41);
        check({ctl, 7'h0, stall}, 16'h4100);
        cyc(65540);
        check(count, 16'hFFFF);
    endtask
    task automatic complete_run();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Whole run needs about 66000 cycles
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        complete_run();
    end
    initial begin
        cyc(8);
        reset_n <= 1'b1;
        cyc(1);
        check({ctl, 7'h0, stall}, 16'h0000);
        t_unlock();
        t_ctl();
        t_break_on();
        complete_run();
    end
endmodule // on_chip_debug_unit_tb
